// ==== dafd_pkg.sv ====
package dafd_pkg;
	// byte offsets inside one array entry
	localparam logic [31:0] DAFD_OFF_ADDR = 32'h0000_0000;
	localparam logic [31:0] DAFD_OFF_CNT = 32'h0000_0004;
	localparam logic [31:0] DAFD_OFF_CTL = 32'h0000_0006;
	localparam logic [31:0] DAFD_OFF_HOLD = 32'h0000_0008;
	localparam logic [31:0] DAFD_OFF_LINK_PLAIN = 32'h0000_0006;
	localparam logic [31:0] DAFD_OFF_LINK_STAT = 32'h0000_000C;
	// entry sizes in bytes
	localparam logic [31:0] DAFD_ENTRY_PLAIN = 32'h0000_0006;
	localparam logic [31:0] DAFD_ENTRY_STAT = 32'h0000_000C;
	// field lengths in bytes
	localparam logic [2:0] DAFD_LEN_ADDR = 3'h4;
	localparam logic [2:0] DAFD_LEN_WORD = 3'h2;
	// count value that terminates an array
	localparam logic [15:0] DAFD_CNT_END = 16'h0000;
	// reset values
	localparam logic [31:0] DAFD_RST_ADDR = 32'h0000_0000;
	localparam logic [15:0] DAFD_RST_WORD = 16'h0000;

	typedef enum logic [1:0] {
		DAFD_F_ADDR = 2'h0,
		DAFD_F_CNT = 2'h1,
		DAFD_F_CTL = 2'h2,
		DAFD_F_LINK = 2'h3
	} dafd_field_t;

	typedef enum logic [2:0] {
		DAFD_S_IDLE = 3'h0,
		DAFD_S_FETCH = 3'h1,
		DAFD_S_CAPT = 3'h3,
		DAFD_S_OFFER = 3'h2,
		DAFD_S_WRBACK = 3'h6,
		DAFD_S_DONE = 3'h7
	} dafd_state_t;
endpackage

// ==== dafd_lane_if.sv ====
`timescale 1ns/1ns
interface dafd_lane_if;
	logic clear;
	logic load;
	logic [1:0] unit;
	logic [15:0] data;
	logic bus16;
	logic little;
	logic [31:0] value;
	modport ctrl (output clear, load, unit, data, bus16, little, input value);
	modport lane (input clear, load, unit, data, bus16, little, output value);
endinterface

// ==== dafd_lane.sv ====
`timescale 1ns/1ns
module dafd_lane (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// assembler control
	dafd_lane_if.lane lp
);
	import dafd_pkg::*;

	logic [31:0] acc;
	logic [31:0] next_acc;

	// place each fetched unit by byte order: big shifts in, little indexes
	always_comb begin
		next_acc = acc;
		if (lp.clear) begin
			next_acc = DAFD_RST_ADDR;
		end else if (lp.load) begin
			if (lp.little && lp.bus16) begin
				next_acc[{lp.unit[0], 4'h0} +: 16] = lp.data;
			end else if (lp.little) begin
				next_acc[{lp.unit, 3'h0} +: 8] = lp.data[7:0];
			end else if (lp.bus16) begin
				next_acc = {acc[15:0], lp.data};
			end else begin
				next_acc = {acc[23:0], lp.data[7:0]};
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc <= DAFD_RST_ADDR;
		end else begin
			acc <= next_acc;
		end
	end

	assign lp.value = acc;

	property p_little16;
		@(posedge clk) disable iff (!rstn)
		lp.load && !lp.clear && lp.bus16 && lp.little && lp.unit == 2'h1 |=> lp.value[31:16] == $past(lp.data);
	endproperty
	a_little16: assert property (p_little16) else $error("little word not placed high");

	property p_little8;
		@(posedge clk) disable iff (!rstn)
		lp.load && !lp.clear && !lp.bus16 && lp.little && lp.unit == 2'h0 |=> lp.value[7:0] == $past(lp.data[7:0]);
	endproperty
	a_little8: assert property (p_little8) else $error("little first byte not placed low");

	property p_big8;
		@(posedge clk) disable iff (!rstn)
		lp.load && !lp.clear && !lp.bus16 && !lp.little
		|=> lp.value[7:0] == $past(lp.data[7:0]) && lp.value[31:8] == $past(lp.value[23:0]);
	endproperty
	a_big8: assert property (p_big8) else $error("big byte not shifted in");
endmodule // dafd_lane

// ==== dafd_fetch.sv ====
`timescale 1ns/1ns
// Functional notes
// - on an 8-bit big-end bus with frame status, entries are 12 bytes: address MSB first, count, status, holding, zero.
// - on an 8-bit little-end bus, address LSB first at 0-3 then count low and high at 4-5.
// - a zero count ends the array and the base address then points at that dummy entry.
// - in linked mode on a 16-bit big-end bus, a 32-bit next-array pointer follows the entry, upper word first.
// - in linked mode on a 16-bit little-end bus, address and pointer are lower word first.
// - in linked mode on an 8-bit bus, the pointer sits at bytes 6 to 9 after the six-byte entry.
// - with frame status enabled in linked mode, the pointer follows at offset 12.
// - status and control words are arranged the same for big-end and little-end arrays.
// - one control bit selects big-end or little-end reading of addresses and counts.
module dafd_fetch (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// channel control
	input wire logic start,
	input wire logic [31:0] base_addr,
	input wire logic bus16,
	input wire logic little_end,
	input wire logic linked_mode,
	input wire logic status_en,
	input wire logic is_rx,
	// memory port
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack,
	// buffer hand-off
	output logic buf_valid,
	output logic [31:0] buf_addr,
	output logic [15:0] buf_count,
	output logic [15:0] buf_ctl_word,
	input wire logic buf_done,
	input wire logic [15:0] rx_status_block_word,
	input wire logic [15:0] rx_count_holding_word,
	// channel status
	output logic busy,
	output logic done,
	output logic [31:0] base_out
);
	import dafd_pkg::*;

	dafd_lane_if lif ();
	dafd_lane u_lane (
		.clk(clk),
		.rstn(rstn),
		.lp(lif.lane)
	);

	function automatic logic [1:0] last_unit(input logic [2:0] len, input logic w16);
		logic [2:0] n;
		n = w16 ? {1'b0, len[2:1]} : len;
		return 2'(n - 3'h1);
	endfunction

	function automatic logic [31:0] unit_addr(input logic [31:0] b, input logic [31:0] off,
		input logic [1:0] u, input logic w16);
		return b + off + (w16 ? {29'h0, u, 1'b0} : {30'h0, u});
	endfunction

	dafd_state_t state, next_state;
	dafd_field_t field, next_field;
	logic [1:0] unit, next_unit;
	logic [31:0] entry_base, next_entry_base;
	logic [31:0] link_ptr, next_link_ptr;
	logic [31:0] field_off, next_field_off;
	logic [15:0] hold_word, next_hold_word;
	logic wr_sel, next_wr_sel;
	logic next_mem_req, next_mem_we, next_buf_valid, next_done;
	logic [31:0] next_mem_addr, next_buf_addr;
	logic [15:0] next_mem_wdata, next_buf_count, next_buf_ctl_word;
	logic [31:0] step_base;
	logic [15:0] wr_word;
	logic wb_needed;

	// the lane follows the fetch; status words ignore the order bit
	assign lif.load = state == DAFD_S_FETCH && mem_ack;
	assign lif.clear = state == DAFD_S_CAPT;
	assign lif.unit = unit;
	assign lif.data = mem_rdata;
	assign lif.bus16 = bus16;
	assign lif.little = little_end && field != DAFD_F_CTL;

	// next entry address: pointer in linked mode, else the next slot
	assign step_base = linked_mode ? link_ptr : entry_base + (status_en ? DAFD_ENTRY_STAT : DAFD_ENTRY_PLAIN);
	assign wb_needed = status_en && is_rx;
	assign wr_word = wr_sel ? hold_word : rx_status_block_word;

	// descriptor walker
	always_comb begin
		next_state = state;
		next_field = field;
		next_unit = unit;
		next_entry_base = entry_base;
		next_link_ptr = link_ptr;
		next_field_off = field_off;
		next_hold_word = hold_word;
		next_wr_sel = wr_sel;
		next_mem_req = mem_req;
		next_mem_we = mem_we;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_buf_valid = buf_valid;
		next_buf_addr = buf_addr;
		next_buf_count = buf_count;
		next_buf_ctl_word = buf_ctl_word;
		next_done = 1'b0;
		case (state)
			DAFD_S_IDLE: begin
				if (start) begin
					next_entry_base = base_addr;
					next_field = DAFD_F_ADDR;
					next_field_off = DAFD_OFF_ADDR;
					next_unit = 2'h0;
					next_mem_addr = unit_addr(base_addr, DAFD_OFF_ADDR, 2'h0, bus16);
					next_mem_req = 1'b1;
					next_mem_we = 1'b0;
					next_state = DAFD_S_FETCH;
				end
			end
			DAFD_S_FETCH: begin
				if (mem_ack) begin
					if (unit == last_unit((field == DAFD_F_ADDR || field == DAFD_F_LINK) ? DAFD_LEN_ADDR
						: DAFD_LEN_WORD, bus16)) begin
						next_mem_req = 1'b0;
						next_state = DAFD_S_CAPT;
					end else begin
						next_unit = 2'(unit + 2'h1);
						next_mem_addr = unit_addr(entry_base, field_off, 2'(unit + 2'h1), bus16);
					end
				end
			end
			DAFD_S_CAPT: begin
				next_unit = 2'h0;
				next_state = DAFD_S_FETCH;
				next_mem_req = 1'b1;
				case (field)
					DAFD_F_ADDR: begin
						next_buf_addr = lif.value;
						next_field = DAFD_F_CNT;
						next_field_off = DAFD_OFF_CNT;
					end
					DAFD_F_CNT: begin
						next_buf_count = lif.value[15:0];
						if (lif.value[15:0] == DAFD_CNT_END) begin
							next_mem_req = 1'b0;
							next_state = DAFD_S_DONE;
							next_done = 1'b1;
						end else if (status_en) begin
							next_field = DAFD_F_CTL;
							next_field_off = DAFD_OFF_CTL;
						end else if (linked_mode) begin
							next_field = DAFD_F_LINK;
							next_field_off = DAFD_OFF_LINK_PLAIN;
						end else begin
							next_mem_req = 1'b0;
							next_buf_valid = 1'b1;
							next_state = DAFD_S_OFFER;
						end
					end
					DAFD_F_CTL: begin
						next_buf_ctl_word = lif.value[15:0];
						if (linked_mode) begin
							next_field = DAFD_F_LINK;
							next_field_off = DAFD_OFF_LINK_STAT;
						end else begin
							next_mem_req = 1'b0;
							next_buf_valid = 1'b1;
							next_state = DAFD_S_OFFER;
						end
					end
					default: begin
						next_link_ptr = lif.value;
						next_mem_req = 1'b0;
						next_buf_valid = 1'b1;
						next_state = DAFD_S_OFFER;
					end
				endcase
				next_mem_addr = unit_addr(entry_base, next_field_off, 2'h0, bus16);
			end
			DAFD_S_OFFER: begin
				if (buf_done) begin
					next_buf_valid = 1'b0;
					next_unit = 2'h0;
					next_mem_req = 1'b1;
					if (wb_needed) begin
						next_hold_word = rx_count_holding_word;
						next_wr_sel = 1'b0;
						next_mem_we = 1'b1;
						next_mem_addr = unit_addr(entry_base, DAFD_OFF_CTL, 2'h0, bus16);
						next_mem_wdata = bus16 ? rx_status_block_word : {8'h00, rx_status_block_word[15:8]};
						next_state = DAFD_S_WRBACK;
					end else begin
						next_entry_base = step_base;
						next_field = DAFD_F_ADDR;
						next_field_off = DAFD_OFF_ADDR;
						next_mem_addr = unit_addr(step_base, DAFD_OFF_ADDR, 2'h0, bus16);
						next_state = DAFD_S_FETCH;
					end
				end
			end
			DAFD_S_WRBACK: begin
				if (mem_ack) begin
					if (!bus16 && unit == 2'h0) begin
						next_unit = 2'h1;
						next_mem_addr = unit_addr(entry_base, wr_sel ? DAFD_OFF_HOLD : DAFD_OFF_CTL, 2'h1, bus16);
						next_mem_wdata = {8'h00, wr_word[7:0]};
					end else if (!wr_sel) begin
						next_wr_sel = 1'b1;
						next_unit = 2'h0;
						next_mem_addr = unit_addr(entry_base, DAFD_OFF_HOLD, 2'h0, bus16);
						next_mem_wdata = bus16 ? hold_word : {8'h00, hold_word[15:8]};
					end else begin
						next_mem_we = 1'b0;
						next_entry_base = step_base;
						next_field = DAFD_F_ADDR;
						next_field_off = DAFD_OFF_ADDR;
						next_unit = 2'h0;
						next_mem_addr = unit_addr(step_base, DAFD_OFF_ADDR, 2'h0, bus16);
						next_state = DAFD_S_FETCH;
					end
				end
			end
			DAFD_S_DONE: begin
				next_state = DAFD_S_IDLE;
			end
			default: begin
				next_state = DAFD_S_IDLE;
				next_mem_req = 1'b0;
				next_buf_valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= DAFD_S_IDLE;
			field <= DAFD_F_ADDR;
			unit <= 2'h0;
			entry_base <= DAFD_RST_ADDR;
			link_ptr <= DAFD_RST_ADDR;
			field_off <= DAFD_OFF_ADDR;
			hold_word <= DAFD_RST_WORD;
			wr_sel <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= DAFD_RST_ADDR;
			mem_wdata <= DAFD_RST_WORD;
			buf_valid <= 1'b0;
			buf_addr <= DAFD_RST_ADDR;
			buf_count <= DAFD_RST_WORD;
			buf_ctl_word <= DAFD_RST_WORD;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			field <= next_field;
			unit <= next_unit;
			entry_base <= next_entry_base;
			link_ptr <= next_link_ptr;
			field_off <= next_field_off;
			hold_word <= next_hold_word;
			wr_sel <= next_wr_sel;
			mem_req <= next_mem_req;
			mem_we <= next_mem_we;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			buf_valid <= next_buf_valid;
			buf_addr <= next_buf_addr;
			buf_count <= next_buf_count;
			buf_ctl_word <= next_buf_ctl_word;
			busy <= next_state != DAFD_S_IDLE;
			done <= next_done;
		end
	end

	// the walking entry address doubles as the base address register
	assign base_out = entry_base;

	property p_term_base;
		@(posedge clk) disable iff (!rstn)
		state == DAFD_S_CAPT && field == DAFD_F_CNT && lif.value[15:0] == DAFD_CNT_END
		|=> done && !mem_req && base_out == $past(entry_base) ##1 !busy;
	endproperty
	a_term_base: assert property (p_term_base) else $error("zero count did not end at dummy entry");

	property p_step_plain;
		@(posedge clk) disable iff (!rstn)
		state == DAFD_S_OFFER && buf_done && !linked_mode && !wb_needed
		|=> mem_addr == $past(entry_base) + ($past(status_en) ? DAFD_ENTRY_STAT : DAFD_ENTRY_PLAIN);
	endproperty
	a_step_plain: assert property (p_step_plain) else $error("next entry not at entry size");

	property p_link_stat;
		@(posedge clk) disable iff (!rstn)
		state == DAFD_S_CAPT && field == DAFD_F_CTL && linked_mode |=> mem_addr == entry_base + DAFD_OFF_LINK_STAT;
	endproperty
	a_link_stat: assert property (p_link_stat) else $error("pointer not fetched at offset 12");

	property p_link_plain;
		@(posedge clk) disable iff (!rstn)
		state == DAFD_S_CAPT && field == DAFD_F_CNT && lif.value[15:0] != DAFD_CNT_END && !status_en && linked_mode
		|=> field == DAFD_F_LINK && mem_addr == entry_base + DAFD_OFF_LINK_PLAIN;
	endproperty
	a_link_plain: assert property (p_link_plain) else $error("pointer not fetched at offset 6");

	property p_link_follow;
		@(posedge clk) disable iff (!rstn)
		state == DAFD_S_OFFER && buf_done && linked_mode && !wb_needed |=> base_out == $past(link_ptr);
	endproperty
	a_link_follow: assert property (p_link_follow) else $error("chain did not follow pointer");

	property p_ctl_order;
		@(posedge clk) disable iff (!rstn)
		state == DAFD_S_FETCH && field == DAFD_F_CTL |-> !lif.little;
	endproperty
	a_ctl_order: assert property (p_ctl_order) else $error("control word order follows end bit");

	property p_order_bit;
		@(posedge clk) disable iff (!rstn)
		state == DAFD_S_FETCH && field != DAFD_F_CTL |-> lif.little == little_end;
	endproperty
	a_order_bit: assert property (p_order_bit) else $error("byte order not taken from control bit");

	property p_req_held;
		@(posedge clk) disable iff (!rstn)
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
	endproperty
	a_req_held: assert property (p_req_held) else $error("memory request dropped before answer");

	c_term: cover property (@(posedge clk) disable iff (!rstn) done);
	c_link: cover property (@(posedge clk) disable iff (!rstn) state == DAFD_S_CAPT && field == DAFD_F_LINK);
	c_wback: cover property (@(posedge clk) disable iff (!rstn) state == DAFD_S_WRBACK && mem_ack && wr_sel);
endmodule // dafd_fetch

// ==== dafd_mem_model.sv ====
`timescale 1ns/1ns
module dafd_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// behaviour selection
	input wire logic bus16,
	input wire logic slow,
	// memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	logic [7:0] mem [0:4095];
	logic [11:0] a;
	logic [15:0] word;
	int wcnt;
	int dly;
	// 16-bit units carry the lower byte address in the high lane
	assign a = mem_addr[11:0];
	assign word = bus16 ? {mem[a], mem[a + 12'h001]} : {~mem[a], mem[a]};
	// read data is valid only in the ack cycle, an inverted pattern otherwise
	assign mem_rdata = mem_ack ? word : ~word;
	// ack one cycle after the request, or after a random wait when slow
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem_ack <= 1'b0;
			wcnt <= 0;
			dly <= 0;
		end else begin
			mem_ack <= 1'b0;
			if (mem_req && !mem_ack) begin
				wcnt <= wcnt + 1;
				if (!slow || wcnt >= dly) begin
					mem_ack <= 1'b1;
					wcnt <= 0;
					dly <= $urandom_range(0, 3);
				end
			end
			if (mem_req && mem_ack && mem_we) begin
				if (bus16) begin
					mem[a] <= mem_wdata[15:8];
					mem[a + 12'h001] <= mem_wdata[7:0];
				end else begin
					mem[a] <= mem_wdata[7:0];
				end
			end
		end
	end
endmodule // dafd_mem_model

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
	import dafd_pkg::*;
	logic clk, rstn, start, bus16, little_end, linked_mode, status_en, is_rx, slow;
	logic mem_req, mem_we, mem_ack, buf_valid, buf_done, busy, done;
	logic [31:0] base_addr, mem_addr, buf_addr, base_out, dummy;
	logic [15:0] mem_wdata, mem_rdata, buf_count, buf_ctl_word, rx_status_block_word, rx_count_holding_word;
	int mismatches, checked, seed;
	logic [31:0] qa[$], qe[$];
	logic [15:0] qc[$], qw[$], qs[$], qh[$];

	dafd_fetch dafd_fetch_inst (.clk(clk), .rstn(rstn), .start(start), .base_addr(base_addr), .bus16(bus16),
		.little_end(little_end), .linked_mode(linked_mode), .status_en(status_en), .is_rx(is_rx),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .buf_valid(buf_valid), .buf_addr(buf_addr), .buf_count(buf_count),
		.buf_ctl_word(buf_ctl_word), .buf_done(buf_done), .rx_status_block_word(rx_status_block_word),
		.rx_count_holding_word(rx_count_holding_word), .busy(busy), .done(done), .base_out(base_out));
	dafd_mem_model dafd_mem_model_inst (.clk(clk), .rstn(rstn), .bus16(bus16), .slow(slow), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

	// compare one result and count it
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic put8(input logic [31:0] a, input logic [7:0] v);
		dafd_mem_model_inst.mem[a[11:0]] = v;
	endtask

	// address or pointer in the selected byte order
	task automatic put32(input logic [31:0] a, input logic [31:0] v);
		logic [7:0] b [4];
		b = '{v[31:24], v[23:16], v[15:8], v[7:0]};
		if (little_end && bus16)
			b = '{v[15:8], v[7:0], v[31:24], v[23:16]};
		if (little_end && !bus16)
			b = '{v[7:0], v[15:8], v[23:16], v[31:24]};
		for (int i = 0; i < 4; i++)
			put8(a + i, b[i]);
	endtask

	task automatic put16(input logic [31:0] a, input logic [15:0] v, input logic swap);
		put8(a, swap ? v[7:0] : v[15:8]);
		put8(a + 1, swap ? v[15:8] : v[7:0]);
	endtask

	// lay out a list of n buffers plus its dummy entry and the expected results
	task automatic build(input int n);
		logic [31:0] ea, nx;
		logic [15:0] cnt, ctl;
		int st;
		st = status_en ? 12 : 6;
		ea = 32'h0000_0100 + 2 * $urandom_range(0, 15);
		base_addr = ea;
		for (int i = 0; i <= n; i++) begin
			for (int j = 0; j < st + 4; j++)
				put8(ea + j, 8'($urandom));
			cnt = (i == n) ? DAFD_CNT_END : 16'($urandom_range(1, 65535));
			ctl = 16'($urandom);
			put32(ea, $urandom);
			put16(ea + 4, cnt, little_end && !bus16);
			if (i == n) begin
				dummy = ea;
				break;
			end
			qa.push_back(buf_addr_of(ea));
			qc.push_back(cnt);
			qw.push_back(ctl);
			qe.push_back(ea);
			if (status_en)
				put16(ea + 6, ctl, 1'b0);
			nx = linked_mode ? ea + st + 4 + 2 * $urandom_range(0, 16) : ea + st;
			if (linked_mode)
				put32(ea + st, nx);
			ea = nx;
		end
	endtask

	// buffer address as stored in memory, read back in the laid-out order
	function automatic logic [31:0] buf_addr_of(input logic [31:0] ea);
		logic [7:0] m [4];
		for (int i = 0; i < 4; i++)
			m[i] = dafd_mem_model_inst.mem[ea[11:0] + i];
		if (little_end && bus16)
			return {m[2], m[3], m[0], m[1]};
		if (little_end)
			return {m[3], m[2], m[1], m[0]};
		return {m[0], m[1], m[2], m[3]};
	endfunction

	// one walk: start, consume every offered buffer, then expect termination
	task automatic run(input int n);
		int k, w;
		build(n);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		base_addr = $urandom;
		k = 0;
		forever begin
			for (w = 0; w < 400 && buf_valid !== 1'b1 && done !== 1'b1; w++)
				@(negedge clk);
			if (done === 1'b1) begin
				chk(base_out, dummy);
				chk(32'(k), 32'(n));
				chk({31'h0, busy}, 32'h0000_0001);
				break;
			end
			// a stalled walk or a buffer past the last one ends the run as a mismatch
			if (buf_valid !== 1'b1 || k >= n) begin
				chk({31'h0, done}, 32'h0000_0001);
				break;
			end
			chk(buf_addr, qa[k]);
			chk({16'h0000, buf_count}, {16'h0000, qc[k]});
			if (status_en && !is_rx)
				chk({16'h0000, buf_ctl_word}, {16'h0000, qw[k]});
			start = 1'b1;
			repeat ($urandom_range(1, 3)) @(negedge clk);
			start = 1'b0;
			rx_status_block_word = 16'($urandom);
			rx_count_holding_word = 16'($urandom);
			qs.push_back(rx_status_block_word);
			qh.push_back(rx_count_holding_word);
			buf_done = 1'b1;
			@(negedge clk);
			buf_done = 1'b0;
			chk({31'h0, buf_valid}, 32'h0000_0000);
			k++;
		end
		// receive status and holding words land high byte first at +6 and +8
		for (int i = 0; i < qe.size() && is_rx && status_en; i++) begin
			chk({16'h0000, dafd_mem_model_inst.mem[qe[i][11:0] + 6], dafd_mem_model_inst.mem[qe[i][11:0] + 7]},
				{16'h0000, qs[i]});
			chk({16'h0000, dafd_mem_model_inst.mem[qe[i][11:0] + 8], dafd_mem_model_inst.mem[qe[i][11:0] + 9]},
				{16'h0000, qh[i]});
		end
		qa = {};
		qc = {};
		qw = {};
		qe = {};
		qs = {};
		qh = {};
	endtask

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// cut a hang short
	initial begin
		#(40 * 60000);
		mismatches++;
		$display("ERROR %0t: walk timed out", $time);
		give_verdict;
	end

	// main sequence: every mode combination, prompt and slow memory
	initial begin
		mismatches = 0;
		checked = 0;
		rstn = 1'b0;
		start = 1'b0;
		base_addr = 32'h0000_0000;
		{slow, is_rx, status_en, linked_mode, little_end, bus16} = 6'h00;
		buf_done = 1'b0;
		rx_status_block_word = 16'h0000;
		rx_count_holding_word = 16'h0000;
		seed = $urandom(69);
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		chk({30'h0, busy, buf_valid}, 32'h0000_0000);
		for (int c = 0; c < 64; c++) begin
			{slow, is_rx, status_en, linked_mode, little_end, bus16} = 6'(c);
			run(c % 4);
			@(negedge clk);
		end
		give_verdict;
	end
endmodule // tb_top
